// *** design/adc_ctrl_pkg.sv ***
// Shared constants, commands and field layouts of the converter control block
package adc_ctrl_pkg;

    // Word and byte geometry of the host data bus
    localparam int DATA_W  = 13;
    localparam int BYTE_W  = 8;
    localparam int UPPER_W = 5;

    // Command field encodings
    typedef enum logic [2:0] {
        CMD_STANDBY  = 3'h0,
        CMD_FULL_CAL = 3'h1,
        CMD_AUTOZERO = 3'h2,
        CMD_IDLE     = 3'h3,
        CMD_START    = 3'h4
    } cmd_type;

    // Control word, most significant field first
    typedef struct packed {
        logic       bus_width_select;
        logic [2:0] cmd;
        logic       sync_in_mode;
        logic       upper_byte_pointer;
        logic       single_ended_clip;
        logic [1:0] acq_sel;
        logic [3:0] mux_sel;
    } ctrl_type;

    // Multiplexer routing toward the analog front end
    typedef struct packed {
        logic [2:0] pos_chan;
        logic       neg_is_common;
        logic [2:0] neg_chan;
    } mux_route_type;

    // Field positions inside a written byte or word
    localparam int HB_BIT       = 7;
    localparam int MUX_SE_BIT   = 3;
    localparam int MUX_POL_BIT  = 0;

    // Values after reset: trigger pin is an input, standby, 8-bit bus
    localparam logic [12:0] CTRL_RESET   = 13'h0100;
    localparam logic [12:0] RESULT_RESET = 13'h0000;

    // Self-timed acquisition lengths in clock cycles
    localparam logic [6:0] ACQ_CYCLES_0 = 7'h09;
    localparam logic [6:0] ACQ_CYCLES_1 = 7'h0F;
    localparam logic [6:0] ACQ_CYCLES_2 = 7'h2F;
    localparam logic [6:0] ACQ_CYCLES_3 = 7'h4F;

    // Calibration averaging
    localparam logic [2:0] CAL_LAST_REP = 3'h7;
    localparam int         CAL_SHIFT    = 3;

    // Wake-up time out of standby, and its length in cycles at 20 MHz
    localparam int CLK_FREQ_MHZ = 20;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES  = (WAKE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

endpackage : adc_ctrl_pkg

// *** design/adc_host_control.sv ***
// Host interface, mode control and sequencing of the sampling converter
//
// Notes on behaviour
// - Writes go to control word, reads return result
// - 8-bit mode drives only low data lines
// - Bus comes up 8 bits wide
// - Pointer bit sends next byte to upper half
// - Upper byte write clears the pointer
// - 8-bit reads: low byte, then high byte
// - 13-bit mode: whole word, pointer ignored
// - Edge select pin picks write latch edge
// - Mux bits route inputs to both outputs
// - Bit 3 single-ended, else pair, bit0 polarity
// - Standby command enters low power, status low
// - Command field decode, reset value standby
// - Other command: status high now, ready later
// - Power-up state is standby
// - Trigger mode: pin input, rising edge converts
// - Self-timed: pin output high during conversion
// - Self-timed acquisition counted in clock cycles
// - Acquisition select maps to 9/15/47/79
// - Self-timed read raises ready, starts counter
// - Trigger mode ignores acquisition select bits
// - Full calibration averages eight offset measurements
// - Each capacitor measured eight times, averaged
// - Result two's complement, upper byte sign-extended
`timescale 1ns/1ps

module adc_host_control #(
    parameter int CAP_COUNT = 12,
    parameter int CAP_W     = $clog2(CAP_COUNT)
) (
    input  wire logic                    SYS_CLK,
    input  wire logic                    NRST,
    input  wire logic                    CS_N,
    input  wire logic                    RD_N,
    input  wire logic                    WR_N,
    input  wire logic                    WRITE_EDGE_SELECT,
    input  wire logic [12:0]             DATA_IN,
    output logic      [12:0]             DATA_OUT,
    output logic      [12:0]             DATA_OE_N,
    input  wire logic                    SYNC_IN,
    output logic                         SYNC_OUT,
    output logic                         SYNC_OE_N,
    output logic                         READY_N,
    output logic                         LOW_POWER_STATUS,
    output adc_ctrl_pkg::mux_route_type  MUX_ROUTE,
    output logic                         SAMPLE_TRACK,
    output logic                         CONV_START,
    input  wire logic                    CONV_DONE,
    input  wire logic [12:0]             CONV_RAW,
    output logic                         MEAS_START,
    output logic                         MEAS_IS_CAP,
    output logic      [CAP_W-1:0]        MEAS_CAP_IDX,
    input  wire logic                    MEAS_DONE,
    input  wire logic [12:0]             MEAS_VALUE,
    output logic      [12:0]             OFFSET_COEF,
    input  wire logic [CAP_W-1:0]        LIN_SEL,
    output logic      [12:0]             LIN_COEF
);

    typedef enum logic [2:0] {
        ST_STANDBY, ST_WAKE, ST_IDLE, ST_ARMED, ST_ACQ, ST_CONV, ST_CAL
    } state_type;

    state_type                state_r;
    adc_ctrl_pkg::ctrl_type   ctrl_r;
    adc_ctrl_pkg::ctrl_type   ctrl_nxt;
    logic                     ctrl_apply;
    logic [7:0]               lo_pend_r;
    logic                     hb_ptr_r;
    logic                     wr_q;
    logic                     rd_q;
    logic                     cs_q;
    logic                     sync_q;
    logic [12:0]              data_q;
    logic                     wr_evt;
    logic [12:0]              wdata;
    logic                     rd_start;
    logic                     rd_end;
    logic                     rd_hi_r;
    logic                     read_done;
    logic                     sync_rise;
    logic [12:0]              result_r;
    logic [12:0]              dout_r;
    logic [6:0]               acq_cnt_r;
    logic [6:0]               acq_len;
    logic [7:0]               wake_cnt_r;
    logic                     lp_r;
    logic                     track_r;
    logic                     conv_start_r;
    logic                     meas_start_r;
    logic                     meas_pend_r;
    logic                     cal_cap_phase_r;
    logic [CAP_W-1:0]         cap_idx_r;
    logic [2:0]               rep_r;
    logic signed [15:0]       acc_r;
    logic signed [15:0]       acc_nxt;
    logic [12:0]              offset_r;
    logic [12:0]              lin_coef_r [CAP_COUNT];
    logic [12:0]              lin_out_r;
    logic [12:0]              corrected;

    // Pin sampling; strobes are synchronous so no extra synchroniser stage
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            wr_q   <= 1'b1;
            rd_q   <= 1'b1;
            cs_q   <= 1'b1;
            sync_q <= 1'b0;
            data_q <= 13'h0000;
        end else begin
            wr_q   <= WR_N;
            rd_q   <= RD_N;
            cs_q   <= CS_N;
            sync_q <= SYNC_IN;
            data_q <= DATA_IN;
        end
    end

    // Rising-edge writes use data held while the strobe was low
    always_comb begin
        if (WRITE_EDGE_SELECT) begin
            wr_evt = wr_q && !WR_N && !CS_N;
            wdata  = DATA_IN;
        end else begin
            wr_evt = !wr_q && WR_N && !cs_q;
            wdata  = data_q;
        end
    end

    assign rd_start  = rd_q && !RD_N && !CS_N;
    assign rd_end    = !rd_q && RD_N && !cs_q;
    assign read_done = rd_end && (ctrl_r.bus_width_select || rd_hi_r);
    assign sync_rise = SYNC_IN && !sync_q;

    // Assemble the next control word; nothing applies on a half-written word
    always_comb begin
        ctrl_nxt   = ctrl_r;
        ctrl_apply = 1'b0;
        if (wr_evt) begin
            if (ctrl_r.bus_width_select) begin
                ctrl_nxt   = wdata;
                ctrl_apply = 1'b1;
            end else if (hb_ptr_r) begin
                ctrl_nxt   = {wdata[4:0], lo_pend_r};
                ctrl_nxt.upper_byte_pointer = 1'b0;
                ctrl_apply = 1'b1;
            end else if (!wdata[adc_ctrl_pkg::HB_BIT]) begin
                ctrl_nxt   = {ctrl_r[12:8], wdata[7:0]};
                ctrl_apply = 1'b1;
            end
        end
    end

    // Control word and byte pointer; reset gives 8-bit bus and standby
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_r    <= adc_ctrl_pkg::CTRL_RESET;
            hb_ptr_r  <= 1'b0;
            lo_pend_r <= 8'h00;
        end else if (wr_evt && !ctrl_r.bus_width_select) begin
            if (hb_ptr_r) begin
                hb_ptr_r <= 1'b0;
                ctrl_r   <= ctrl_nxt;
            end else if (wdata[adc_ctrl_pkg::HB_BIT]) begin
                hb_ptr_r  <= 1'b1;
                lo_pend_r <= wdata[7:0];
            end else begin
                ctrl_r <= ctrl_nxt;
            end
        end else if (ctrl_apply) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read byte order and registered read data
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rd_hi_r <= 1'b0;
            dout_r  <= 13'h0000;
        end else begin
            if (rd_start) begin
                if (ctrl_r.bus_width_select)
                    dout_r <= result_r;
                else if (rd_hi_r)
                    dout_r <= {5'h00, {3{result_r[12]}},
                               result_r[12:8]};
                else
                    dout_r <= {5'h00, result_r[7:0]};
            end
            if (rd_end && !ctrl_r.bus_width_select)
                rd_hi_r <= !rd_hi_r;
            else if (ctrl_r.bus_width_select)
                rd_hi_r <= 1'b0;
        end
    end

    // Only the low lane is driven on a byte-wide bus
    always_comb begin
        DATA_OE_N = 13'h1FFF;
        if (!CS_N && !RD_N) begin
            DATA_OE_N[7:0] = 8'h00;
            if (ctrl_r.bus_width_select)
                DATA_OE_N[12:8] = 5'h00;
        end
    end
    assign DATA_OUT = dout_r;

    // Acquisition length lookup
    always_comb begin
        unique case (ctrl_r.acq_sel)
            2'h0: acq_len = adc_ctrl_pkg::ACQ_CYCLES_0;
            2'h1: acq_len = adc_ctrl_pkg::ACQ_CYCLES_1;
            2'h2: acq_len = adc_ctrl_pkg::ACQ_CYCLES_2;
            2'h3: acq_len = adc_ctrl_pkg::ACQ_CYCLES_3;
        endcase
    end

    // Main sequencer; a new standby, calibration or idle command takes precedence over activity
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_r      <= ST_STANDBY;
            wake_cnt_r   <= 8'h00;
            acq_cnt_r    <= 7'h00;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            if (ctrl_apply && ctrl_nxt.cmd != ctrl_r.cmd
                    && ctrl_nxt.cmd == adc_ctrl_pkg::CMD_STANDBY) begin
                state_r <= ST_STANDBY;
            end else if (ctrl_apply
                    && ctrl_nxt.cmd != adc_ctrl_pkg::CMD_STANDBY) begin
                if (state_r == ST_STANDBY) begin
                    state_r    <= ST_WAKE;
                    wake_cnt_r <= 8'(adc_ctrl_pkg::WAKE_CYCLES);
                end else if (ctrl_nxt.cmd == adc_ctrl_pkg::CMD_FULL_CAL
                        || ctrl_nxt.cmd == adc_ctrl_pkg::CMD_AUTOZERO) begin
                    state_r <= ST_CAL;
                end else if (ctrl_nxt.cmd == adc_ctrl_pkg::CMD_IDLE) begin
                    state_r <= ST_IDLE;
                end
            end else begin
                unique case (state_r)
                    ST_STANDBY: ;
                    ST_WAKE: begin
                        wake_cnt_r <= wake_cnt_r - 8'h01;
                        if (wake_cnt_r == 8'h01) begin
                            if (ctrl_r.cmd == adc_ctrl_pkg::CMD_FULL_CAL
                                || ctrl_r.cmd == adc_ctrl_pkg::CMD_AUTOZERO)
                                state_r <= ST_CAL;
                            else
                                state_r <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                        if (ctrl_r.cmd == adc_ctrl_pkg::CMD_START) begin
                            if (read_done && !ctrl_r.sync_in_mode) begin
                                state_r   <= ST_ACQ;
                                acq_cnt_r <= acq_len;
                            end else if (read_done) begin
                                state_r <= ST_ARMED;
                            end else if (ctrl_r.sync_in_mode && sync_rise) begin
                                state_r      <= ST_CONV;
                                conv_start_r <= 1'b1;
                            end
                        end
                    end
                    ST_ARMED: begin
                        if (!ctrl_r.sync_in_mode) begin
                            state_r   <= ST_ACQ;
                            acq_cnt_r <= acq_len;
                        end else if (sync_rise) begin
                            state_r      <= ST_CONV;
                            conv_start_r <= 1'b1;
                        end
                    end
                    ST_ACQ: begin
                        acq_cnt_r <= acq_cnt_r - 7'h01;
                        if (acq_cnt_r == 7'h01) begin
                            state_r      <= ST_CONV;
                            conv_start_r <= 1'b1;
                        end
                    end
                    ST_CONV: begin
                        if (CONV_DONE)
                            state_r <= ST_IDLE;
                    end
                    ST_CAL: begin
                        if (MEAS_DONE && meas_pend_r
                            && (ctrl_r.cmd == adc_ctrl_pkg::CMD_AUTOZERO
                                || (cal_cap_phase_r
                                    && rep_r == adc_ctrl_pkg::CAL_LAST_REP
                                    && cap_idx_r == CAP_W'(CAP_COUNT - 1))))
                            state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign acc_nxt = acc_r + 16'(signed'(MEAS_VALUE));

    // Full calibration: averages of eight, offset first, then each capacitor; auto-zero takes one offset reading
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            meas_start_r    <= 1'b0;
            meas_pend_r     <= 1'b0;
            cal_cap_phase_r <= 1'b0;
            cap_idx_r       <= '0;
            rep_r           <= 3'h0;
            acc_r           <= 16'h0000;
            offset_r        <= 13'h0000;
        end else begin
            meas_start_r <= 1'b0;
            if (state_r != ST_CAL) begin
                meas_pend_r     <= 1'b0;
                cal_cap_phase_r <= 1'b0;
                cap_idx_r       <= '0;
                rep_r           <= 3'h0;
                acc_r           <= 16'h0000;
            end else if (!meas_pend_r) begin
                meas_start_r <= 1'b1;
                meas_pend_r  <= 1'b1;
            end else if (MEAS_DONE) begin
                meas_pend_r <= 1'b0;
                if (ctrl_r.cmd == adc_ctrl_pkg::CMD_AUTOZERO) begin
                    offset_r <= MEAS_VALUE;
                end else if (rep_r != adc_ctrl_pkg::CAL_LAST_REP) begin
                    rep_r <= rep_r + 3'h1;
                    acc_r <= acc_nxt;
                end else begin
                    rep_r <= 3'h0;
                    acc_r <= 16'h0000;
                    if (!cal_cap_phase_r) begin
                        offset_r <= 13'(acc_nxt >>>
                                        adc_ctrl_pkg::CAL_SHIFT);
                        cal_cap_phase_r <= 1'b1;
                    end else begin
                        cap_idx_r <= cap_idx_r + CAP_W'(1);
                    end
                end
            end
        end
    end

    // Linearity coefficient store, filled as each capacitor finishes
    always_ff @(posedge SYS_CLK) begin
        if (state_r == ST_CAL && meas_pend_r && MEAS_DONE && cal_cap_phase_r
                && rep_r == adc_ctrl_pkg::CAL_LAST_REP
                && ctrl_r.cmd == adc_ctrl_pkg::CMD_FULL_CAL)
            lin_coef_r[cap_idx_r] <= 13'(acc_nxt >>>
                                         adc_ctrl_pkg::CAL_SHIFT);
        lin_out_r <= lin_coef_r[LIN_SEL];
    end

    // Offset-corrected result; clip negatives when the clip bit is set
    assign corrected = CONV_RAW - offset_r;
    always_ff @(posedge SYS_CLK) begin
        if (!NRST)
            result_r <= adc_ctrl_pkg::RESULT_RESET;
        else if (state_r == ST_CONV && CONV_DONE)
            result_r <= (ctrl_r.single_ended_clip && corrected[12])
                        ? 13'h0000 : corrected;
    end

    // Status pins and the sample tracking window
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            lp_r    <= 1'b0;
            track_r <= 1'b0;
        end else begin
            if (ctrl_apply)
                lp_r <= (ctrl_nxt.cmd != adc_ctrl_pkg::CMD_STANDBY);
            if (conv_start_r)
                track_r <= 1'b0;
            else if ((ctrl_apply && ctrl_nxt.mux_sel != ctrl_r.mux_sel)
                     || ((state_r == ST_CONV && CONV_DONE)
                         || (state_r == ST_CAL && state_r != ST_IDLE
                             && MEAS_DONE && meas_pend_r)))
                track_r <= 1'b1;
        end
    end

    // Mux decode: bit 3 picks single-ended against the common input
    always_comb begin
        MUX_ROUTE = '0;
        if (ctrl_r.mux_sel[adc_ctrl_pkg::MUX_SE_BIT]) begin
            MUX_ROUTE.pos_chan      = ctrl_r.mux_sel[2:0];
            MUX_ROUTE.neg_is_common = 1'b1;
        end else begin
            MUX_ROUTE.pos_chan = ctrl_r.mux_sel[2:0];
            MUX_ROUTE.neg_chan = {ctrl_r.mux_sel[2:1],
                                  !ctrl_r.mux_sel[adc_ctrl_pkg::MUX_POL_BIT]};
        end
    end

    assign READY_N          = (state_r != ST_IDLE);
    assign LOW_POWER_STATUS = lp_r;
    assign SYNC_OE_N        = ctrl_r.sync_in_mode;
    assign SYNC_OUT         = (state_r == ST_CONV);
    assign SAMPLE_TRACK     = track_r;
    assign CONV_START       = conv_start_r;
    assign MEAS_START       = meas_start_r;
    assign MEAS_IS_CAP      = cal_cap_phase_r;
    assign MEAS_CAP_IDX     = cap_idx_r;
    assign OFFSET_COEF      = offset_r;
    assign LIN_COEF         = lin_out_r;

    // Helper: running length of the current self-timed acquisition window, cleared outside it
    logic [6:0] acq_seen_r;
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || state_r != ST_ACQ)
            acq_seen_r <= 7'h00;
        else
            acq_seen_r <= acq_seen_r + 7'h01;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    standby_entry_a: assert property (
        ctrl_apply && ctrl_nxt.cmd == adc_ctrl_pkg::CMD_STANDBY
        |=> !LOW_POWER_STATUS && READY_N)
        else $error("standby command did not lower status");
    wake_order_a: assert property (
        state_r == ST_STANDBY && ctrl_apply
        && ctrl_nxt.cmd == adc_ctrl_pkg::CMD_IDLE
        |=> (LOW_POWER_STATUS && READY_N) [*2])
        else $error("wake sequence out of order");
    hb_clear_a: assert property (
        wr_evt && hb_ptr_r && !ctrl_r.bus_width_select
        |=> !hb_ptr_r && !ctrl_r.upper_byte_pointer)
        else $error("upper byte pointer not cleared");
    narrow_bus_a: assert property (
        !ctrl_r.bus_width_select |-> DATA_OE_N[12:8] == 5'h1F)
        else $error("upper lines driven in byte mode");
    acq_length_a: assert property (
        state_r == ST_ACQ ##1 state_r == ST_CONV
        |-> $past(acq_seen_r) + 7'h01 == $past(acq_len, 2) ||
            $past(acq_seen_r) + 7'h01 == $past(acq_len))
        else $error("acquisition window has wrong length");
    read_ready_a: assert property (
        state_r == ST_IDLE && read_done && !ctrl_apply
        && ctrl_r.cmd == adc_ctrl_pkg::CMD_START && !ctrl_r.sync_in_mode
        |=> READY_N ##[9:79] CONV_START)
        else $error("self-timed read did not start acquisition");
    trig_start_a: assert property (
        state_r == ST_ARMED && ctrl_r.sync_in_mode && sync_rise
        && !ctrl_apply |=> CONV_START && SYNC_OE_N)
        else $error("trigger edge did not start conversion");
    sign_ext_a: assert property (
        rd_start && !ctrl_r.bus_width_select && rd_hi_r
        |=> DATA_OUT[7:5] == {3{result_r[12]}})
        else $error("upper byte not sign extended");

    full_cal_c:  cover property (state_r == ST_CAL && cal_cap_phase_r
                                 ##1 state_r == ST_IDLE);
    self_conv_c: cover property (state_r == ST_ACQ ##1 state_r == ST_CONV
                                 ##[1:50] state_r == ST_IDLE);
    two_byte_c:  cover property (wr_evt && hb_ptr_r ##1 ctrl_r.bus_width_select);

endmodule : adc_host_control

// *** verification/conv_model.sv ***
// Stand-in for the converter core and its calibration measurements
`timescale 1ns/1ps
module conv_model (
    input  wire logic        clk,
    input  wire logic        cs,
    input  wire logic        ms,
    input  wire logic [3:0]  lat,
    input  wire logic [12:0] raw_in,
    output logic             cd,
    output logic [12:0]      cr,
    output logic             md,
    output logic [12:0]      mv
);
    int cc = -1;
    int mc = -1;
    int mk = 0;
    // Answers come lat cycles late; data toggles outside its pulse
    // Each measurement answers with its running count, so averages differ
    always @(posedge clk) begin
        cd <= (cc == 0);
        md <= (mc == 0);
        mv <= (mc == 0) ? 13'(mk) : 13'h1555;
        if (mc == 0) mk <= mk + 1;
        cr <= (cc == 0) ? raw_in : ~raw_in;
        cc <= cs ? int'(lat) : (cc >= 0 ? cc - 1 : -1);
        mc <= ms ? int'(lat) : (mc >= 0 ? mc - 1 : -1);
    end
endmodule : conv_model

// *** verification/sampling_adc_host_control_bench.sv ***
// Self-checking bench for the converter host control block
`timescale 1ns/1ps
module sampling_adc_host_control_bench;
    logic SYS_CLK = 0, NRST = 0, CS_N = 1, RD_N = 1, WR_N = 1, wes = 1;
    logic READY_N, LOW_POWER_STATUS, SYNC_OE_N;
    logic SYNC_OUT, SAMPLE_TRACK, sy = 0, wide = 0, ls = 0;
    logic [12:0] OFFSET_COEF, LIN_COEF;
    logic CONV_START, CONV_DONE, MEAS_START, MEAS_DONE;
    logic [3:0]  lat = 4'h0;
    logic [12:0] DATA_IN = 13'h0000, DATA_OUT, DATA_OE_N, CONV_RAW;
    logic [12:0] MEAS_VALUE, raw = 13'h0000, last = 13'h0000, q[$];
    adc_ctrl_pkg::mux_route_type MUX_ROUTE;
    int seed = 77925, err_total = 0, check_count = 0, cyc = 0;
    int n, got, acq_n = 0, acq[4] = '{9, 15, 47, 79};
    adc_host_control #(.CAP_COUNT(2)) dut_u (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N),
        .WR_N(WR_N), .WRITE_EDGE_SELECT(wes), .DATA_IN(DATA_IN),
        .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .SYNC_IN(sy),
        .SYNC_OUT(SYNC_OUT), .SYNC_OE_N(SYNC_OE_N), .READY_N(READY_N),
        .LOW_POWER_STATUS(LOW_POWER_STATUS), .MUX_ROUTE(MUX_ROUTE),
        .SAMPLE_TRACK(SAMPLE_TRACK), .CONV_START(CONV_START),
        .CONV_DONE(CONV_DONE),
        .CONV_RAW(CONV_RAW), .MEAS_START(MEAS_START), .MEAS_IS_CAP(),
        .MEAS_CAP_IDX(), .MEAS_DONE(MEAS_DONE), .MEAS_VALUE(MEAS_VALUE),
        .OFFSET_COEF(OFFSET_COEF), .LIN_SEL(ls), .LIN_COEF(LIN_COEF));
    conv_model far_u (.clk(SYS_CLK), .cs(CONV_START), .ms(MEAS_START),
        .lat(lat), .raw_in(raw), .cd(CONV_DONE), .cr(CONV_RAW),
        .md(MEAS_DONE), .mv(MEAS_VALUE));
    initial forever #25 SYS_CLK = ~SYS_CLK;
    task chk(input logic [12:0] s, input logic [12:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("FAIL t=%0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // One host cycle; strobes held two cycles so either latch edge is safe
    task bus(input logic w, input logic [7:0] d);
        @(negedge SYS_CLK);
        CS_N = 0;
        DATA_IN = {5'h00, d};
        if (w) WR_N = 0;
        else RD_N = 0;
        repeat (2) @(negedge SYS_CLK);
        if (!w) chk(DATA_OE_N, wide ? 13'h0000 : 13'h1F00);
        WR_N = 1;
        RD_N = 1;
        repeat (2) @(negedge SYS_CLK);
        CS_N = 1;
    endtask : bus
    task wait_rdy;
        n = 0;
        while (READY_N !== 1'b0 && n < 3000) begin
            @(negedge SYS_CLK);
            n++;
        end
        chk(13'(READY_N), 13'h0000);
    endtask : wait_rdy
    // Each completed read is matched against the oldest expected byte, or whole word on the wide bus
    always @(posedge RD_N)
        if (q.size() > 0)
            chk(wide ? DATA_OUT : 13'(DATA_OUT[7:0]), q.pop_front());
    // Acquisition length: cycles with ready high before the start pulse
    always @(negedge SYS_CLK) begin
        // Trigger pin high and tracking window still open at the start pulse
        if (CONV_START === 1'b1) begin
            got = acq_n;
            chk(13'({SYNC_OUT, SAMPLE_TRACK}), 13'h0003);
        end
        acq_n = (READY_N === 1'b1) ? acq_n + 1 : 0;
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge SYS_CLK);
        NRST = 1;
        chk(13'({READY_N, LOW_POWER_STATUS, SYNC_OE_N}), 13'h0005);
        bus(1, 8'h80);
        chk(13'(LOW_POWER_STATUS), 13'h0000);
        bus(1, 8'h05);
        chk(13'(LOW_POWER_STATUS), 13'h0001);
        wait_rdy();
        $display("auto-zero done");
        for (int i = 0; i < 4; i++) begin
            wes = i[0];
            raw = 13'($random(seed));
            lat = 4'($random(seed));
            bus(1, {2'b10, 2'(i), 4'hB});
            bus(1, 8'h08);
            chk(13'({SYNC_OE_N, MUX_ROUTE}), 13'h0038);
            q.push_back(13'(last[7:0]));
            q.push_back(13'({{3{last[12]}}, last[12:8]}));
            bus(0, 8'h00);
            bus(0, 8'h00);
            wait_rdy();
            chk(13'(got >= acq[i] && got <= acq[i] + 2), 13'h0001);
            last = raw;
            $display("conversion %0d done", i);
        end
        bus(1, 8'h80);
        bus(1, 8'h00);
        chk(13'(LOW_POWER_STATUS), 13'h0000);
        q.push_back(13'(last[7:0]));
        q.push_back(13'({{3{last[12]}}, last[12:8]}));
        bus(0, 8'h00);
        bus(0, 8'h00);
        $display("standby done");
        // Wake with the idle command, then a differential trigger conversion
        bus(1, 8'h80);
        bus(1, 8'h07);
        chk(13'(LOW_POWER_STATUS), 13'h0001);
        wait_rdy();
        bus(1, 8'h85);
        bus(1, 8'h09);
        chk(13'({SYNC_OE_N, MUX_ROUTE}), 13'h00D4);
        q.push_back(13'(last[7:0]));
        q.push_back(13'({{3{last[12]}}, last[12:8]}));
        bus(0, 8'h00);
        bus(0, 8'h00);
        raw = 13'($random(seed));
        @(negedge SYS_CLK);
        sy = 1;
        repeat (2) @(negedge SYS_CLK);
        sy = 0;
        wait_rdy();
        last = raw;
        $display("trigger conversion done");
        // Full calibration: model answers 1..8, 9..16, 17..24 in turn
        bus(1, 8'h80);
        bus(1, 8'h03);
        wait_rdy();
        chk(OFFSET_COEF, 13'h0004);
        chk(LIN_COEF, 13'h000C);
        ls = 1;
        repeat (2) @(negedge SYS_CLK);
        chk(LIN_COEF, 13'h0014);
        $display("full calibration done");
        // Switch to the wide bus; new results carry the offset of 4
        bus(1, 8'h80);
        bus(1, 8'h18);
        wide = 1;
        q.push_back(last);
        raw = 13'($random(seed));
        bus(0, 8'h00);
        wait_rdy();
        q.push_back(raw - 13'h0004);
        bus(0, 8'h00);
        chk(13'(q.size()), 13'h0000);
        $display("wide bus done");
        print_verdict();
    end
endmodule : sampling_adc_host_control_bench
